// *** logic/dcbh_pkg.sv ***
`default_nettype none
package dcbh_pkg;
    localparam int CLK_NS            = 25;
    localparam int DATA_W            = 16;
    localparam int LOW_W             = 16;
    localparam int WIN_W             = 4;
    localparam int EXT_W             = 4;
    localparam int ADDR_W            = LOW_W + WIN_W + EXT_W;
    localparam int ADDR_SETUP_NS     = 50;
    localparam int ADDR_SETUP_CYC    = (ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYCLE_NS          = 500;
    localparam int CYCLE_CYC         = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_EXIT          = CYCLE_CYC - ADDR_SETUP_CYC - 2;
    localparam int TRANSFER_ACKNOWLEDGE_MAX_NS       = 350;
    localparam int TRANSFER_ACKNOWLEDGE_MAX_CYC      = TRANSFER_ACKNOWLEDGE_MAX_NS / CLK_NS;
    localparam int ACK_MARGIN_CYC    = 2;
    localparam int RELEASE_NS        = 100;
    localparam int RELEASE_CYC       = (RELEASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int REFRESH_ROW_NS    = 15000;
    localparam int REFRESH_ROW_CYC   = REFRESH_ROW_NS / CLK_NS;
    localparam int REFRESH_PULSE_NS  = 100;
    localparam int REFRESH_PULSE_CYC = (REFRESH_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int INIT_NS           = 1000;
    localparam int INIT_CYC          = (INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SINCE_W           = 5;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_STROBE = 3'h3,
        ST_HOLD   = 3'h2,
        ST_GAP    = 3'h6,
        ST_INIT   = 3'h4
    } dcbh_state_e;
endpackage : dcbh_pkg
`default_nettype wire

// *** logic/dcbh_ref_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface dcbh_ref_if;
    logic en;
    logic req;
    logic grant;
    logic busy;
    logic level;
    modport gen (input en, input grant, output req, output busy, output level);
    modport arb (output en, output grant, input req, input busy, input level);
endinterface : dcbh_ref_if
`default_nettype wire

// *** logic/dcbh_refresh.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcbh_refresh #(
    parameter int PERIOD = dcbh_pkg::REFRESH_ROW_CYC,
    parameter int PULSE  = dcbh_pkg::REFRESH_PULSE_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    dcbh_ref_if.gen   ref_bus
);
    localparam int CW    = $clog2(PERIOD + 1);
    localparam int PW    = $clog2(PULSE + 1);
    localparam int SLACK = 64;
    localparam int LIMIT = PERIOD + SLACK;

    if (PULSE < 1 || PERIOD < PULSE + 4) begin : g_chk
        $error("refresh period or pulse out of range");
    end

    logic [CW-1:0] tick;
    logic [PW-1:0] pcnt;
    logic          req_q;
    logic          lvl;
    logic [CW:0]   since_pulse;

    wire tick_done = tick == CW'(PERIOD - 1);
    wire pulse_end = lvl && pcnt == PW'(PULSE - 1);

    assign ref_bus.req   = req_q && ref_bus.en;
    assign ref_bus.busy  = lvl;
    assign ref_bus.level = lvl;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick  <= '0;
            req_q <= 1'b0;
        end else begin
            tick <= (!ref_bus.en || tick_done) ? '0 : tick + 1'b1;
            if (ref_bus.en && tick_done) begin
                req_q <= 1'b1;
            end else if (ref_bus.grant || !ref_bus.en) begin
                req_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lvl  <= 1'b0;
            pcnt <= '0;
        end else if (ref_bus.grant) begin
            lvl  <= 1'b1;
            pcnt <= '0;
        end else if (lvl) begin
            pcnt <= pcnt + 1'b1;
            lvl  <= !pulse_end;
        end
    end

    // checking aid: cycles since the last refresh pulse while enabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            since_pulse <= '0;
        end else if (!ref_bus.en || lvl) begin
            since_pulse <= '0;
        end else if (since_pulse != '1) begin
            since_pulse <= since_pulse + 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_pulse_high;
        lvl[*4];
    endsequence

    AST_REF_PULSE: assert property ($rose(lvl) |-> s_pulse_high ##1 !lvl)
        else $error("refresh pulse width wrong");
    AST_REF_PERIOD: assert property (since_pulse <= (CW+1)'(LIMIT))
        else $error("refresh pulses too far apart");
endmodule : dcbh_refresh
`default_nettype wire

// *** logic/dcbh_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcbh_top #(
    parameter int ACK_WAIT   = dcbh_pkg::TRANSFER_ACKNOWLEDGE_MAX_CYC + dcbh_pkg::ACK_MARGIN_CYC,
    parameter int INIT_WIDTH = dcbh_pkg::INIT_CYC
) (
    input  wire logic                          CORE_CLK,
    input  wire logic                          RSTN,
    input  wire logic                          HOST_REFRESH_EN,
    input  wire logic                          REQ_VALID,
    output logic                               REQ_READY,
    input  wire logic                          REQ_WRITE,
    input  wire logic                          REQ_BYTE,
    input  wire logic [dcbh_pkg::ADDR_W-1:0]   REQ_ADDR,
    input  wire logic [dcbh_pkg::DATA_W-1:0]   REQ_WDATA,
    output logic                               RSP_VALID,
    output logic [dcbh_pkg::DATA_W-1:0]        RSP_RDATA,
    output logic                               RSP_FAULT,
    output logic [dcbh_pkg::LOW_W-1:0]         BUS_ADDRESS_LOW,
    output logic [dcbh_pkg::WIN_W-1:0]         WINDOW_SELECT_ADDRESS,
    output logic [dcbh_pkg::EXT_W-1:0]         EXTENDED_FIELD_ADDRESS,
    output logic                               READ_COMMAND_STROBE_N,
    output logic                               WRITE_COMMAND_STROBE_N,
    output logic                               UPPER_BYTE_SELECT_N,
    input  wire logic [dcbh_pkg::DATA_W-1:0]   BUS_DATA_LINES_IN,
    output logic [dcbh_pkg::DATA_W-1:0]        BUS_DATA_LINES_OUT,
    output logic [dcbh_pkg::DATA_W-1:0]        BUS_DATA_LINES_OE,
    input  wire logic                          EARLY_ACKNOWLEDGE_N,
    input  wire logic                          TRANSFER_ACKNOWLEDGE_N,
    output logic                               INIT_N,
    output logic                               BUS_DRIVEN_REFRESH
);
    localparam int DW       = dcbh_pkg::DATA_W;
    localparam int HW       = DW / 2;
    localparam int SW       = dcbh_pkg::SINCE_W;
    localparam int INIT_LO  = INIT_WIDTH - 1;
    localparam int ACK_HI   = ACK_WAIT + 1;

    if (ACK_WAIT < dcbh_pkg::TRANSFER_ACKNOWLEDGE_MAX_CYC || ACK_WAIT > 255 || INIT_WIDTH < 2
        || INIT_WIDTH > 255 || dcbh_pkg::CYCLE_CYC >= (1 << SW)) begin : g_chk
        $error("dcbh_top parameter out of range");
    end

    dcbh_ref_if ref_bus ();

    dcbh_refresh u_refresh (
        .clk     (CORE_CLK),
        .rstn    (RSTN),
        .ref_bus (ref_bus.gen)
    );

    dcbh_pkg::dcbh_state_e state;
    logic [7:0]            cnt;
    logic [SW-1:0]         since;
    logic                  cmd;
    logic                  wr_q;
    logic                  byte_q;
    logic                  oe_q;
    logic                  fault_q;
    logic                  rsp_q;
    logic                  init_q;
    logic [dcbh_pkg::ADDR_W-1:0] addr_q;
    logic [DW-1:0]         wdata_q;
    logic [DW-1:0]         rdata_q;

    function automatic logic [DW-1:0] lane_mask(input logic is_byte);
        lane_mask = is_byte ? {{HW{1'b0}}, {HW{1'b1}}} : {DW{1'b1}};
    endfunction

    wire in_idle    = state == dcbh_pkg::ST_IDLE;
    wire ref_hold   = ref_bus.req || ref_bus.busy;
    wire accept     = in_idle && !ref_hold && REQ_VALID;
    wire setup_done = cnt == 8'(dcbh_pkg::ADDR_SETUP_CYC - 1);
    wire transfer_acknowledge_hit   = state == dcbh_pkg::ST_STROBE && !TRANSFER_ACKNOWLEDGE_N;
    wire ack_late   = state == dcbh_pkg::ST_STROBE && cnt == 8'(ACK_WAIT - 1);
    wire released   = EARLY_ACKNOWLEDGE_N && TRANSFER_ACKNOWLEDGE_N;
    wire hold_done  = state == dcbh_pkg::ST_HOLD
                      && (released || cnt == 8'(dcbh_pkg::RELEASE_CYC + dcbh_pkg::ACK_MARGIN_CYC));
    wire gap_done   = since >= SW'(dcbh_pkg::GAP_EXIT);
    wire init_done  = cnt == 8'(INIT_WIDTH);
    wire [DW-1:0] lane_in = BUS_DATA_LINES_IN & lane_mask(byte_q);

    assign ref_bus.en     = HOST_REFRESH_EN;
    assign ref_bus.grant  = in_idle && ref_bus.req && !ref_bus.busy;
    assign REQ_READY      = in_idle && !ref_hold;
    assign RSP_VALID      = rsp_q;
    assign RSP_RDATA      = rdata_q;
    assign RSP_FAULT      = fault_q;
    assign INIT_N         = init_q;
    assign BUS_DRIVEN_REFRESH = ref_bus.level;

    // address split onto low, window and extended lines
    assign BUS_ADDRESS_LOW        = addr_q[dcbh_pkg::LOW_W-1:0];
    assign WINDOW_SELECT_ADDRESS  = addr_q[dcbh_pkg::LOW_W +: dcbh_pkg::WIN_W];
    assign EXTENDED_FIELD_ADDRESS = addr_q[dcbh_pkg::ADDR_W-1 -: dcbh_pkg::EXT_W];
    assign READ_COMMAND_STROBE_N  = !(cmd && !wr_q);
    assign WRITE_COMMAND_STROBE_N = !(cmd && wr_q);
    assign UPPER_BYTE_SELECT_N    = byte_q;
    assign BUS_DATA_LINES_OUT     = wdata_q;
    assign BUS_DATA_LINES_OE      = oe_q ? lane_mask(byte_q) : '0;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= dcbh_pkg::ST_INIT;
            cnt   <= '0;
        end else begin
            cnt <= cnt + 1'b1;
            unique case (state)
                dcbh_pkg::ST_INIT: begin
                    if (init_done) begin
                        state <= dcbh_pkg::ST_IDLE;
                    end
                end
                dcbh_pkg::ST_IDLE: begin
                    cnt <= '0;
                    if (accept) begin
                        state <= dcbh_pkg::ST_SETUP;
                    end
                end
                dcbh_pkg::ST_SETUP: begin
                    if (setup_done) begin
                        state <= dcbh_pkg::ST_STROBE;
                        cnt   <= '0;
                    end
                end
                dcbh_pkg::ST_STROBE: begin
                    if (transfer_acknowledge_hit || ack_late) begin
                        state <= dcbh_pkg::ST_HOLD;
                        cnt   <= '0;
                    end
                end
                dcbh_pkg::ST_HOLD: begin
                    if (hold_done) begin
                        state <= dcbh_pkg::ST_GAP;
                    end
                end
                dcbh_pkg::ST_GAP: begin
                    if (gap_done) begin
                        state <= dcbh_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= dcbh_pkg::ST_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            since <= '1;
        end else if (state == dcbh_pkg::ST_SETUP && setup_done) begin
            since <= '0;
        end else if (since != '1) begin
            since <= since + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            addr_q  <= '0;
            wdata_q <= '0;
            wr_q    <= 1'b0;
            byte_q  <= 1'b0;
        end else if (accept) begin
            addr_q  <= REQ_ADDR;
            wdata_q <= REQ_WDATA & lane_mask(REQ_BYTE);
            wr_q    <= REQ_WRITE;
            byte_q  <= REQ_BYTE;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmd  <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            if (state == dcbh_pkg::ST_SETUP && setup_done) begin
                cmd <= 1'b1;
            end else if (transfer_acknowledge_hit || ack_late) begin
                cmd <= 1'b0;
            end
            if (accept) begin
                oe_q <= REQ_WRITE;
            end else if (hold_done) begin
                oe_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q <= '0;
            fault_q <= 1'b0;
            rsp_q   <= 1'b0;
            init_q  <= 1'b1;
        end else begin
            rsp_q  <= hold_done;
            init_q <= state != dcbh_pkg::ST_INIT || init_done;
            if (transfer_acknowledge_hit && !wr_q) begin
                rdata_q <= lane_in;
            end
            if (transfer_acknowledge_hit || ack_late) begin
                fault_q <= ack_late && !transfer_acknowledge_hit;
            end
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_addr_held;
        $stable(addr_q) ##1 $stable(addr_q);
    endsequence

    sequence s_strobe_start;
        $rose(cmd);
    endsequence

    AST_ADDR_SETUP: assert property (accept |=> ##1 s_addr_held ##0 $rose(cmd))
        else $error("strobe not two cycles after address");
    AST_ADDR_BEFORE: assert property (s_strobe_start |-> $stable(addr_q) && $past(state) == dcbh_pkg::ST_SETUP)
        else $error("address moved at strobe");
    AST_WDATA_READY: assert property ((s_strobe_start and wr_q) |-> oe_q && $past(oe_q, 2))
        else $error("write data not driven before strobe");
    AST_SPACING: assert property (s_strobe_start |-> $past(since) >= SW'(dcbh_pkg::CYCLE_CYC - 1))
        else $error("cycles closer than minimum");
    AST_ONE_STROBE: assert property (READ_COMMAND_STROBE_N || WRITE_COMMAND_STROBE_N)
        else $error("both strobes low");
    AST_STROBE_END: assert property (s_strobe_start |-> ##[1:ACK_HI] !cmd)
        else $error("strobe never released");
    AST_NO_REF_IN_CMD: assert property (cmd |-> !BUS_DRIVEN_REFRESH)
        else $error("refresh pulse during command");
    AST_READ_CAPTURE: assert property (transfer_acknowledge_hit && !wr_q |=> rdata_q == $past(lane_in) ##[1:7] rsp_q)
        else $error("read data not captured");
    AST_INIT_PULSE: assert property ($fell(init_q) |-> ##INIT_LO !init_q ##1 init_q)
        else $error("initialise pulse width wrong");
    AST_LANES: assert property (oe_q |-> BUS_DATA_LINES_OE == lane_mask(byte_q))
        else $error("data lanes wrong for mode");
endmodule : dcbh_top
`default_nettype wire

// *** test/dcbh_card_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcbh_card_model #(
    parameter logic [3:0] WIN_START = 4'h2,
    parameter logic [3:0] WIN_END   = 4'h5,
    parameter logic [3:0] EXT_SEL   = 4'hA
) (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        init_n,
    input  wire logic [23:0] addr,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        byte_n,
    input  wire logic        refresh,
    input  wire logic [15:0] bus,
    output logic      [15:0] card_data,
    output logic      [15:0] card_oe,
    output logic             eack_n,
    output logic             transfer_acknowledge_n
);
    logic [15:0]      mem [int];
    logic [15:0]      rdata, wcap, pat;
    logic [23:0]      prev_addr;
    logic             prev_cmd, prev_ref, active, drv;
    int               age, since_cmd, since_ref, timer, viol, ref_count, ref_gap_max;
    wire logic        cmd  = !rd_n || !wr_n;
    wire logic        hit  = addr[19:16] >= WIN_START && addr[19:16] <= WIN_END
                             && addr[23:20] == EXT_SEL;
    wire logic [15:0] mask = byte_n ? 16'h00FF : 16'hFFFF;
    wire logic [22:0] key  = addr[23:1];
    // undriven lanes show a pattern that flips every cycle
    assign card_oe   = drv ? mask : 16'h0000;
    assign card_data = (card_oe & rdata) | (~card_oe & pat);

    initial begin
        {prev_cmd, prev_ref, active, drv} = 4'h0;
        {eack_n, transfer_acknowledge_n} = 2'h3;
        {rdata, wcap, pat, prev_addr} = '0;
        {age, timer, viol, ref_count, ref_gap_max, since_ref} = '0;
        since_cmd = 100;
    end

    always @(posedge clk) begin
        age = (addr != prev_addr) ? 0 : age + 1;
        prev_addr = addr;
        since_cmd++;
        since_ref++;
        pat <= ~pat;
        if (!rd_n && !wr_n || refresh && cmd || cmd && prev_cmd && age == 0)
            viol++;
        if (cmd && !prev_cmd) begin
            if (age < 2 || since_cmd < 20)
                viol++;
            since_cmd = 0;
            timer = 0;
            active = hit;
            wcap = bus;
        end
        if (cmd && active) begin
            timer++;
            if (timer == 2)
                eack_n <= 1'h0;
            if (timer == (slow ? 12 : 4)) begin
                transfer_acknowledge_n <= 1'h0;
                drv <= !rd_n;
                if (!mem.exists(key))
                    mem[key] = 16'h0000;
                if (!wr_n && (bus & mask) !== (wcap & mask))
                    viol++;
                if (!wr_n && !byte_n)
                    mem[key] = bus;
                else if (!wr_n && addr[0])
                    mem[key][15:8] = bus[7:0];
                else if (!wr_n)
                    mem[key][7:0] = bus[7:0];
                else if (byte_n)
                    rdata <= {8'h00, addr[0] ? mem[key][15:8] : mem[key][7:0]};
                else
                    rdata <= mem[key];
            end
        end
        if (!cmd || !init_n) begin
            {eack_n, transfer_acknowledge_n, drv} <= 3'h6;
            active = 1'h0;
        end
        if (refresh && !prev_ref) begin
            if (ref_count > 0 && since_ref > ref_gap_max)
                ref_gap_max = since_ref;
            ref_count++;
            since_ref = 0;
        end
        prev_cmd = cmd;
        prev_ref = refresh;
    end
endmodule : dcbh_card_model
`default_nettype wire

// *** test/tb_dram_card_bus_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_dram_card_bus_slave;
    logic              core_clk        = 1'h0;
    logic              rstn            = 1'h0;
    logic              host_refresh_en = 1'h0;
    logic              req_valid       = 1'h0;
    logic              req_write       = 1'h0;
    logic              req_byte        = 1'h0;
    logic              slow            = 1'h0;
    logic [23:0]       req_addr        = 24'h000000;
    logic [15:0]       req_wdata       = 16'h0000;
    logic              req_ready, rsp_valid, rsp_fault, rd_n, wr_n, byte_n;
    logic              eack_n, transfer_acknowledge_n, init_n, refresh;
    logic [15:0]       rsp_rdata, host_out, host_oe, card_data, low_addr;
    logic [3:0]        win_addr, ext_addr;
    wire logic [15:0]  bus_lines = (host_oe & host_out) | (~host_oe & card_data);
    int                num_errors = 0;
    int                n_checks   = 0;

    dcbh_top u_dcbh_top (
        .CORE_CLK(core_clk), .RSTN(rstn), .HOST_REFRESH_EN(host_refresh_en),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
        .REQ_BYTE(req_byte), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_FAULT(rsp_fault),
        .BUS_ADDRESS_LOW(low_addr), .WINDOW_SELECT_ADDRESS(win_addr),
        .EXTENDED_FIELD_ADDRESS(ext_addr), .READ_COMMAND_STROBE_N(rd_n),
        .WRITE_COMMAND_STROBE_N(wr_n), .UPPER_BYTE_SELECT_N(byte_n),
        .BUS_DATA_LINES_IN(bus_lines), .BUS_DATA_LINES_OUT(host_out),
        .BUS_DATA_LINES_OE(host_oe), .EARLY_ACKNOWLEDGE_N(eack_n),
        .TRANSFER_ACKNOWLEDGE_N(transfer_acknowledge_n), .INIT_N(init_n), .BUS_DRIVEN_REFRESH(refresh)
    );
    dcbh_card_model u_dcbh_card_model (
        .clk(core_clk), .slow(slow), .init_n(init_n), .addr({ext_addr, win_addr, low_addr}),
        .rd_n(rd_n), .wr_n(wr_n), .byte_n(byte_n), .refresh(refresh), .bus(bus_lines),
        .card_data(card_data), .card_oe(), .eack_n(eack_n), .transfer_acknowledge_n(transfer_acknowledge_n)
    );

    always #12.5 core_clk = ~core_clk;

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_up(input string what);
        num_errors++;
        $display("unexpected %s: expected handshake seen none", what);
        conclude();
    endtask : give_up

    task automatic access(input logic wr, input logic bm, input logic [23:0] a,
                          input logic [15:0] wd, output logic [15:0] rd, output logic f);
        int i;
        @(negedge core_clk);
        {req_valid, req_write, req_byte, req_addr, req_wdata} = {1'h1, wr, bm, a, wd};
        for (i = 0; i < 2000 && req_ready !== 1'h1; i++)
            @(negedge core_clk);
        if (req_ready !== 1'h1)
            give_up("request taken");
        @(negedge core_clk);
        req_valid = 1'h0;
        for (i = 0; i < 200 && rsp_valid !== 1'h1; i++)
            @(negedge core_clk);
        if (rsp_valid !== 1'h1)
            give_up("response");
        rd = rsp_rdata;
        f = rsp_fault;
    endtask : access

    task automatic t_init;
        int n = 0;
        for (int i = 0; i < 100; i++) begin
            @(negedge core_clk);
            if (init_n === 1'h0)
                n++;
        end
        check("initialise low cycles", 40, n);
    endtask : t_init

    task automatic t_word;
        logic [15:0] rd;
        logic        f;
        access(1'h1, 1'h0, 24'hA2_0000, 16'h5AC3, rd, f);
        access(1'h1, 1'h0, 24'hA5_FFFE, 16'h0FF0, rd, f);
        access(1'h0, 1'h0, 24'hA2_0000, 16'h0000, rd, f);
        check("word read", 16'h5AC3, rd);
        access(1'h0, 1'h0, 24'hA2_0000, 16'h0000, rd, f);
        check("repeated read", 16'h5AC3, rd);
        access(1'h0, 1'h0, 24'hA5_FFFE, 16'h0000, rd, f);
        check("top of window read", 16'h0FF0, rd);
        check("in window fault", 0, f);
    endtask : t_word

    task automatic t_byte;
        logic [15:0] rd;
        logic        f;
        slow = 1'h1;
        access(1'h1, 1'h0, 24'hA3_0100, 16'hFFFF, rd, f);
        access(1'h1, 1'h1, 24'hA3_0100, 16'hAB11, rd, f);
        access(1'h1, 1'h1, 24'hA3_0101, 16'hCD22, rd, f);
        access(1'h0, 1'h0, 24'hA3_0100, 16'h0000, rd, f);
        check("word after byte writes", 16'h2211, rd);
        access(1'h0, 1'h1, 24'hA3_0101, 16'h0000, rd, f);
        check("odd byte read", 16'h0022, rd);
        access(1'h0, 1'h1, 24'hA3_0100, 16'h0000, rd, f);
        check("even byte read", 16'h0011, rd);
        check("slow read fault", 0, f);
        slow = 1'h0;
    endtask : t_byte

    task automatic t_window;
        logic [15:0] rd;
        logic        f;
        logic [23:0] bad [3] = '{24'hA6_0000, 24'hA1_FFFE, 24'hB3_0000};
        for (int i = 0; i < 6; i++) begin
            access(1'(i % 2), 1'h0, bad[i / 2], 16'h1234, rd, f);
            check("outside window fault", 1, f);
        end
        access(1'h0, 1'h0, 24'hA3_0100, 16'h0000, rd, f);
        check("inside window after misses", 0, f);
    endtask : t_window

    task automatic t_refresh;
        logic [15:0] rd;
        logic        f;
        check("pulses while card refreshes", 0, u_dcbh_card_model.ref_count);
        host_refresh_en = 1'h1;
        for (int k = 0; k < 36; k++) begin
            access(1'h1, 1'h0, 24'hA3_0200 + 24'(2 * k), 16'h1000 + 16'(k), rd, f);
            access(1'h0, 1'h0, 24'hA3_0200 + 24'(2 * k), 16'h0000, rd, f);
            check("read among refreshes", 16'h1000 + 16'(k), rd);
        end
        host_refresh_en = 1'h0;
        check("at least two refreshes", 1, u_dcbh_card_model.ref_count >= 2);
        check("refresh spacing in bound", 1, u_dcbh_card_model.ref_gap_max
              <= dcbh_pkg::REFRESH_ROW_CYC + 2 * dcbh_pkg::CYCLE_CYC);
        check("bus protocol faults", 0, u_dcbh_card_model.viol);
    endtask : t_refresh

    initial begin
        repeat (20) @(negedge core_clk);
        rstn = 1'h1;
        t_init();
        t_word();
        t_byte();
        t_window();
        t_refresh();
        conclude();
    end
endmodule : tb_dram_card_bus_slave
`default_nettype wire
